// >>> msc_pkg.sv
// Shared constants, register map and carrier types of the MAC statistics block
package msc_pkg;
  localparam int NCNT = 18;

  // Register offsets
  localparam logic [7:0] OFF_NET_CTRL = 8'h00;
  localparam logic [7:0] OFF_NET_CFG  = 8'h04;
  localparam logic [7:0] OFF_PQUANT   = 8'hBC;
  localparam logic [7:0] OFF_SER_STAT = 8'hC0;

  // Counter indices
  localparam int C_RXPAUSE = 0;
  localparam int C_TXGOOD  = 1;
  localparam int C_ONECOL  = 2;
  localparam int C_MULTI   = 3;
  localparam int C_RXGOOD  = 4;
  localparam int C_FCS     = 5;
  localparam int C_ALIGN   = 6;
  localparam int C_DEFER   = 7;
  localparam int C_LATE    = 8;
  localparam int C_ABAND   = 9;
  localparam int C_STARVE  = 10;
  localparam int C_CRS     = 11;
  localparam int C_PHYERR  = 12;
  localparam int C_LONGOK  = 13;
  localparam int C_LONGBAD = 14;
  localparam int C_RUNT    = 15;
  localparam int C_SQE     = 16;
  localparam int C_TXPAUSE = 17;

  localparam logic [7:0] CNT_OFF [NCNT] = '{
    8'h3C, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C,
    8'h60, 8'h64, 8'h68, 8'h74, 8'h78, 8'h7C, 8'h80, 8'h84, 8'h8C};
  localparam int CNT_W [NCNT] = '{
    16, 32, 16, 16, 24, 8, 8, 16, 8, 8, 8, 8, 8, 8, 8, 8, 8, 16};
  localparam logic [31:0] CNT_RST = 32'h0;

  // Control and configuration fields
  localparam int CTRL_RX_GATE = 2;
  localparam int CFG_SPEED    = 0;
  localparam int CFG_FULL_DUP = 1;
  localparam int CFG_LONG_OK  = 8;
  localparam logic [15:0] PQUANT_RST = 16'hFFFF;

  // Serial status word fields
  localparam int STAT_LSB = 16;
  localparam int STAT_W   = 5;

  // Frame length limits in bytes
  localparam logic [13:0] LEN_MIN      = 14'h0040;
  localparam logic [13:0] LEN_STD_MAX  = 14'h05EE;
  localparam logic [13:0] LEN_LONG_MAX = 14'h07D0;

  // Serial receive segment layout
  localparam int SEG_LEN = 10;
  localparam int SEG_DV  = 1;
  localparam int SEG_SPD = 2;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } msc_bus_s;

  typedef struct packed {
    logic        done;
    logic        crc_bad;
    logic        dribble;
    logic        sym_err;
    logic        pause;
    logic [13:0] len;
  } msc_rx_s;

  typedef struct packed {
    logic       done;
    logic       underrun;
    logic       abandoned;
    logic       late;
    logic       deferred;
    logic       crs_err;
    logic       sqe_miss;
    logic       pause;
    logic [4:0] coll;
  } msc_tx_s;
endpackage

// >>> msc_sat_cnt.sv
// Saturating clear-on-read event counter
`timescale 1ns/1ps
module msc_sat_cnt #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         inc,
  input  wire logic         clr,
  output logic [W-1:0]      count
);
  // Widths beyond one register word cannot be served
  if (W < 1 || W > 32) begin : g_bad_w
    $error("msc_sat_cnt width out of range");
  end

  // Clear wins over the old value, but a same-cycle event still counts
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= W'(msc_pkg::CNT_RST);
    end else if (clr) begin
      count <= inc ? W'(1) : '0;
    end else if (inc && count != '1) begin // Hold at all ones
      count <= count + W'(1);
    end
  end
endmodule

// >>> msc_ser_status.sv
// Recovers link status bits from the serial receive stream
`timescale 1ns/1ps
module msc_ser_status (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  input  wire logic                      ser_clk,
  input  wire logic                      ser_sync,
  input  wire logic                      ser_rxd,
  output logic [msc_pkg::STAT_W-1:0]     status
);
  logic [2:0]                 s1;
  logic [2:0]                 s2;
  logic                       clk_d;
  logic [3:0]                 pos;
  logic [msc_pkg::SEG_LEN-1:0] seg;
  logic                       edge_r;

  // Two-stage synchronisers for the pins
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      clk_d <= 1'b0;
    end else begin
      s1 <= {ser_clk, ser_sync, ser_rxd};
      s2 <= s1;
      clk_d <= s2[2];
    end
  end

  assign edge_r = s2[2] && !clk_d;

  // Segment bit position, restarted by the sync bit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pos <= 4'h0;
      seg <= '0;
    end else if (edge_r) begin
      seg[s2[1] ? 4'h0 : pos] <= s2[0];
      pos <= s2[1] ? 4'h1 : pos + 4'h1;
    end
  end

  // Latch status from a finished segment that carried no data, as the next one starts
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= '0;
    end else if (edge_r && s2[1] && pos == 4'(msc_pkg::SEG_LEN) && !seg[msc_pkg::SEG_DV]) begin
      status <= {seg[msc_pkg::SEG_SPD], seg[msc_pkg::SEG_SPD+1], seg[msc_pkg::SEG_SPD+2],
                 seg[msc_pkg::SEG_SPD+3], seg[msc_pkg::SEG_SPD+4]};
    end
  end
endmodule

// >>> msc_stats.sv
// MAC statistics counter bank and serial status register
//
// What this block does
// - Each counter holds at all ones rather than wrapping.
// - Reading a counter returns its value and clears it.
// - Receive counters move only while the receive gate bit is set.
// - 16-bit counter of good received pause frames.
// - 32-bit counter of frames sent without underrun or retry overflow.
// - 16-bit counter of frames sent after exactly one collision.
// - 24-bit counter of good received frames in the legal length range.
// - 8-bit counter of whole-byte frames with bad CRC, legal length.
// - 8-bit counter of odd-bit frames with bad truncated CRC, legal length.
// - 16-bit counter of frames deferred on first try, no collision or underrun.
// - 8-bit counter of late collisions, also seen as ordinary collisions.
// - 8-bit counter of frames dropped after sixteen collisions.
// - 8-bit underrun counter; an underrun frame moves no other counter.
// - Half duplex only: 8-bit counter of carrier sense errors; such frames still count as sent.
// - 8-bit counter of frames received with the PHY error input.
// - 8-bit counter of clean over-length received frames.
// - 8-bit counter of over-length received frames with errors.
// - 8-bit counter of short frames with no CRC or alignment error.
// - Half duplex: 8-bit counter of missing collision heartbeat after send.
// - 16-bit counter of transmitted pause frames.
// - Status word bits 20..16: speed, duplex, link, jabber, false carrier.
// - Long-frame bit raises the length limit from 1518 to 2000 bytes.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module msc_stats (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire msc_pkg::msc_bus_s bus,
  output logic [31:0]            rd_data,
  input  wire msc_pkg::msc_rx_s  rx_ev,
  input  wire msc_pkg::msc_tx_s  tx_ev,
  input  wire logic              ser_clk,
  input  wire logic              ser_sync,
  input  wire logic              ser_rxd,
  output logic                   rx_gate,
  output logic                   long_frame_en,
  output logic                   full_duplex,
  output logic                   speed_100,
  output logic [15:0]            pause_quantum
);
  logic [msc_pkg::NCNT-1:0] inc;
  logic [msc_pkg::NCNT-1:0] clr;
  logic [31:0]              cnt_val [msc_pkg::NCNT];
  logic [msc_pkg::STAT_W-1:0] ser_stat;
  logic [31:0]              next_rd_data;
  logic [13:0]              max_len;
  logic                     len_ok;
  logic                     len_long;
  logic                     len_short;
  logic                     fcs_err;
  logic                     align_err;
  logic                     rx_clean;
  logic                     rx_go;
  logic                     tx_go;
  logic                     tx_ok;
  logic                     half;

  // Configuration and control registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_gate <= 1'b0;
    end else if (bus.wr && bus.addr == msc_pkg::OFF_NET_CTRL) begin
      rx_gate <= bus.wdata[msc_pkg::CTRL_RX_GATE];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      long_frame_en <= 1'b0;
      full_duplex <= 1'b0;
      speed_100 <= 1'b0;
    end else if (bus.wr && bus.addr == msc_pkg::OFF_NET_CFG) begin
      long_frame_en <= bus.wdata[msc_pkg::CFG_LONG_OK];
      full_duplex <= bus.wdata[msc_pkg::CFG_FULL_DUP];
      speed_100 <= bus.wdata[msc_pkg::CFG_SPEED];
    end
  end

  // Pause quantum register used by the pause generator
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pause_quantum <= msc_pkg::PQUANT_RST;
    end else if (bus.wr && bus.addr == msc_pkg::OFF_PQUANT) begin
      pause_quantum <= bus.wdata[15:0];
    end
  end

  // Receive frame classification
  always_comb begin
    max_len = long_frame_en ? msc_pkg::LEN_LONG_MAX : msc_pkg::LEN_STD_MAX;
    len_short = rx_ev.len < msc_pkg::LEN_MIN;
    len_long = rx_ev.len > max_len;
    len_ok = !len_short && !len_long;
    fcs_err = rx_ev.crc_bad && !rx_ev.dribble;
    align_err = rx_ev.crc_bad && rx_ev.dribble;
    rx_clean = !rx_ev.crc_bad && !rx_ev.sym_err;
    rx_go = rx_ev.done && rx_gate;
  end

  // Transmit outcome: an underrun frame is shut out of every other counter
  always_comb begin
    half = !full_duplex;
    tx_go = tx_ev.done && !tx_ev.underrun;
    tx_ok = tx_go && !tx_ev.abandoned;
  end

  // Increment requests per counter
  always_comb begin
    inc = '0;
    inc[msc_pkg::C_RXGOOD]  = rx_go && len_ok && rx_clean;
    inc[msc_pkg::C_RXPAUSE] = rx_go && len_ok && rx_clean && rx_ev.pause;
    inc[msc_pkg::C_FCS]     = rx_go && len_ok && fcs_err;
    inc[msc_pkg::C_ALIGN]   = rx_go && len_ok && align_err;
    inc[msc_pkg::C_PHYERR]  = rx_go && rx_ev.sym_err;
    inc[msc_pkg::C_LONGOK]  = rx_go && len_long && rx_clean;
    inc[msc_pkg::C_LONGBAD] = rx_go && len_long && !rx_clean;
    inc[msc_pkg::C_RUNT]    = rx_go && len_short && !rx_ev.crc_bad;
    inc[msc_pkg::C_TXGOOD]  = tx_ok;
    inc[msc_pkg::C_ONECOL]  = tx_ok && tx_ev.coll == 5'h01;
    inc[msc_pkg::C_MULTI]   = tx_ok && tx_ev.coll > 5'h01;
    inc[msc_pkg::C_DEFER]   = tx_go && tx_ev.deferred && tx_ev.coll == 5'h00;
    inc[msc_pkg::C_LATE]    = tx_go && tx_ev.late;
    inc[msc_pkg::C_ABAND]   = tx_go && tx_ev.abandoned;
    inc[msc_pkg::C_STARVE]  = tx_ev.done && tx_ev.underrun;
    inc[msc_pkg::C_CRS]     = tx_go && tx_ev.crs_err && half;
    inc[msc_pkg::C_SQE]     = tx_go && tx_ev.sqe_miss && half;
    inc[msc_pkg::C_TXPAUSE] = tx_ok && tx_ev.pause;
  end

  // Counter bank; a read of a counter clears it
  for (genvar i = 0; i < msc_pkg::NCNT; i++) begin : g_cnt
    localparam int W = msc_pkg::CNT_W[i];
    logic [W-1:0] q;

    assign clr[i] = bus.rd && bus.addr == msc_pkg::CNT_OFF[i];

    msc_sat_cnt #(.W(W)) u_cnt (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .inc     (inc[i]),
      .clr     (clr[i]),
      .count   (q)
    );

    if (W == 32) begin : g_full
      assign cnt_val[i] = q;
    end else begin : g_pad
      assign cnt_val[i] = {{(32-W){1'b0}}, q};
    end
  end

  // Serial status recovery
  msc_ser_status u_ser (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .ser_clk  (ser_clk),
    .ser_sync (ser_sync),
    .ser_rxd  (ser_rxd),
    .status   (ser_stat)
  );

  // Read data selection; unmapped offsets read zero
  always_comb begin
    next_rd_data = 32'h0;
    unique case (bus.addr)
      msc_pkg::OFF_NET_CTRL: next_rd_data[msc_pkg::CTRL_RX_GATE] = rx_gate;
      msc_pkg::OFF_NET_CFG: begin
        next_rd_data[msc_pkg::CFG_LONG_OK] = long_frame_en;
        next_rd_data[msc_pkg::CFG_FULL_DUP] = full_duplex;
        next_rd_data[msc_pkg::CFG_SPEED] = speed_100;
      end
      msc_pkg::OFF_PQUANT: next_rd_data[15:0] = pause_quantum;
      msc_pkg::OFF_SER_STAT: begin
        next_rd_data[msc_pkg::STAT_LSB +: msc_pkg::STAT_W] = ser_stat;
      end
      default: begin
        for (int k = 0; k < msc_pkg::NCNT; k++) begin
          if (bus.addr == msc_pkg::CNT_OFF[k]) begin
            next_rd_data = cnt_val[k];
          end
        end
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 32'h0;
    end else begin
      rd_data <= bus.rd ? next_rd_data : 32'h0;
    end
  end

  // Saturated 8-bit counter stays put on further events
  sat_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cnt_val[msc_pkg::C_FCS] == 32'h0000_00FF && !clr[msc_pkg::C_FCS]
    |=> cnt_val[msc_pkg::C_FCS] == 32'h0000_00FF)
    else $error("CRC error counter left saturation");

  // Read returns the old value and the counter restarts
  read_clears_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bus.rd && bus.addr == 8'h40 && !inc[msc_pkg::C_TXGOOD]
    |=> rd_data == $past(cnt_val[msc_pkg::C_TXGOOD]) && cnt_val[msc_pkg::C_TXGOOD] == 32'h0)
    else $error("counter read did not return and clear");

  // Event in the clearing cycle is kept
  read_keeps_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clr[msc_pkg::C_TXGOOD] && inc[msc_pkg::C_TXGOOD] |=> cnt_val[msc_pkg::C_TXGOOD] == 32'h1)
    else $error("event lost on clear");

  // Closed receive gate freezes receive counters
  gate_freeze_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !rx_gate && !clr[msc_pkg::C_RXGOOD] |=> $stable(cnt_val[msc_pkg::C_RXGOOD]))
    else $error("receive counter moved with gate closed");

  // Pause frames counted are always good frames too
  pause_good_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    inc[msc_pkg::C_RXPAUSE] |-> rx_gate && rx_ev.pause && !rx_ev.crc_bad && !rx_ev.sym_err
    && rx_ev.len >= 14'h0040 && rx_ev.len <= (long_frame_en ? 14'h07D0 : 14'h05EE))
    else $error("bad pause frame counted");

  // Underrun frame touches only its own counter
  starve_only_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    tx_ev.done && tx_ev.underrun
    |-> inc[msc_pkg::C_STARVE] && !inc[msc_pkg::C_TXGOOD] && !inc[msc_pkg::C_CRS]
        && !inc[msc_pkg::C_ABAND] && !inc[msc_pkg::C_LATE] && !inc[msc_pkg::C_SQE]
        && !inc[msc_pkg::C_ONECOL] && !inc[msc_pkg::C_MULTI] && !inc[msc_pkg::C_DEFER] && !inc[msc_pkg::C_TXPAUSE])
    else $error("underrun frame counted elsewhere");

  // Duplex gating of carrier and heartbeat counters
  half_only_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    full_duplex |-> !inc[msc_pkg::C_CRS] && !inc[msc_pkg::C_SQE])
    else $error("half duplex counter moved in full duplex");

  // Length limit follows the long-frame bit
  long_limit_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rx_go && rx_clean && rx_ev.len == 14'h07D0
    |-> (long_frame_en ? inc[msc_pkg::C_RXGOOD] : inc[msc_pkg::C_LONGOK]))
    else $error("2000-byte frame classified wrongly");

  // Narrow counter reads show zero above its width
  high_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bus.rd && bus.addr == 8'h50 |=> rd_data[31:8] == 24'h0)
    else $error("bits above counter width not zero");

  // Status word keeps reserved bits clear
  stat_shape_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bus.rd && bus.addr == 8'hC0 |=> rd_data[31:21] == 11'h0 && rd_data[15:0] == 16'h0
    && rd_data[20:16] == $past(ser_stat))
    else $error("status word malformed");

  // Every frame sent without underrun or retry overflow steps the count
  tx_count_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    tx_ev.done && !tx_ev.underrun && !tx_ev.abandoned && !clr[msc_pkg::C_TXGOOD]
    |=> cnt_val[msc_pkg::C_TXGOOD] == $past(cnt_val[msc_pkg::C_TXGOOD]) + 32'h1)
    else $error("good transmit not counted");

  // Single collision count needs exactly one collision and a clean send
  one_coll_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    inc[msc_pkg::C_ONECOL]
    |-> tx_ev.coll == 5'h01 && !tx_ev.underrun && !tx_ev.abandoned)
    else $error("single collision counted wrongly");

  // Good frame of legal length is counted
  rx_good_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rx_gate && rx_ev.done && !rx_ev.crc_bad && !rx_ev.sym_err && rx_ev.len >= 14'h0040
    |-> rx_ev.len > 14'h05EE || inc[msc_pkg::C_RXGOOD])
    else $error("good frame not counted");

  // CRC error count takes whole-byte frames of legal length only
  fcs_only_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    inc[msc_pkg::C_FCS]
    |-> rx_ev.crc_bad && !rx_ev.dribble && rx_ev.len >= 14'h0040 && rx_ev.len <= 14'h07D0)
    else $error("CRC error counted wrongly");

  // Alignment count takes odd-bit frames with bad CRC
  align_only_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    inc[msc_pkg::C_ALIGN]
    |-> rx_ev.crc_bad && rx_ev.dribble && rx_ev.len >= 14'h0040 && rx_ev.len <= 14'h07D0)
    else $error("alignment error counted wrongly");

  // Deferral count excludes collided and underrun frames
  defer_only_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    inc[msc_pkg::C_DEFER]
    |-> tx_ev.deferred && tx_ev.coll == 5'h00 && !tx_ev.underrun)
    else $error("deferral counted wrongly");

  // Late collision in a sent frame is counted
  late_count_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    tx_ev.done && tx_ev.late && !tx_ev.underrun
    |-> inc[msc_pkg::C_LATE])
    else $error("late collision missed");

  // Frame dropped after sixteen collisions is counted, not as sent
  tx_abandon_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    tx_ev.done && tx_ev.abandoned && !tx_ev.underrun
    |-> inc[msc_pkg::C_ABAND] && !inc[msc_pkg::C_TXGOOD])
    else $error("abandoned frame counted wrongly");

  // PHY error during an admitted frame is counted
  phy_err_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rx_gate && rx_ev.done && rx_ev.sym_err
    |-> inc[msc_pkg::C_PHYERR])
    else $error("PHY error frame missed");

  // Clean over-length count needs an error-free long frame
  long_clean_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    inc[msc_pkg::C_LONGOK]
    |-> rx_ev.len > 14'h05EE && !rx_ev.crc_bad && !rx_ev.sym_err)
    else $error("clean long frame counted wrongly");

  // Faulty over-length count needs a long frame with an error
  long_bad_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    inc[msc_pkg::C_LONGBAD]
    |-> rx_ev.len > 14'h05EE && (rx_ev.crc_bad || rx_ev.sym_err))
    else $error("faulty long frame counted wrongly");

  // Short frame count excludes CRC and alignment errors
  runt_only_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    inc[msc_pkg::C_RUNT]
    |-> rx_ev.len < 14'h0040 && !rx_ev.crc_bad)
    else $error("short frame counted wrongly");

  // Missing heartbeat in half duplex is counted
  sqe_count_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !full_duplex && tx_ev.done && tx_ev.sqe_miss && !tx_ev.underrun
    |-> inc[msc_pkg::C_SQE])
    else $error("heartbeat miss not counted");

  // Pause frame sent is counted along with the good frame
  tx_pause_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    tx_ev.done && tx_ev.pause && !tx_ev.underrun && !tx_ev.abandoned
    |-> inc[msc_pkg::C_TXPAUSE] && inc[msc_pkg::C_TXGOOD])
    else $error("sent pause frame not counted");

  // Closed receive gate holds back the pause, CRC error, alignment and PHY error counts
  gate_all_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !rx_gate
    |-> !inc[msc_pkg::C_RXPAUSE] && !inc[msc_pkg::C_FCS] && !inc[msc_pkg::C_ALIGN] && !inc[msc_pkg::C_PHYERR])
    else $error("receive event counted with gate closed");
endmodule

// >>> msc_phy_model.sv
// Behavioural serial PHY that sends link status segments to the statistics block
`timescale 1ns/1ps
module msc_phy_model (
  input  wire logic       en,
  input  wire logic [4:0] st,
  output logic            ser_clk,
  output logic            ser_sync,
  output logic            ser_rxd
);
  initial begin
    ser_clk  = 1'b0;
    ser_sync = 1'b0;
    ser_rxd  = 1'b0;
  end

  // Segments of ten bits, data valid low, status in bits 2..6; clock stands still when idle
  always begin
    wait (en);
    for (int i = 0; i < 10; i++) begin
      ser_sync = (i == 0);
      ser_rxd  = (i >= 2 && i <= 6) ? st[6 - i] : 1'b0;
      #20 ser_clk = 1'b1;
      #20 ser_clk = 1'b0;
    end
    // Idle line shows a changed level so a stale bit is never mistaken for data
    if (!en) begin
      ser_sync = 1'b0;
      ser_rxd  = ~ser_rxd;
    end
  end
endmodule

// >>> tb.sv
// Self-checking testbench of the MAC statistics counter bank
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic             gate;
    logic [1:0]       cfg;
    msc_pkg::msc_rx_s rx;
    msc_pkg::msc_tx_s tx;
    logic [17:0]      m;
  } msc_row_s;

  logic              sys_clk;
  logic              rst_b;
  msc_pkg::msc_bus_s bus;
  logic [31:0]       rd_data;
  msc_pkg::msc_rx_s  rx_ev;
  msc_pkg::msc_tx_s  tx_ev;
  logic              ser_clk, ser_sync, ser_rxd;
  logic              rx_gate, long_frame_en, full_duplex, speed_100;
  logic [15:0]       pause_quantum;
  logic              phy_en;
  logic [4:0]        phy_st;
  int                error_cnt, n_tests, cyc;
  msc_row_s          rows[$];
  logic [31:0]       v;
  localparam msc_pkg::msc_rx_s RX0 = '0;
  localparam msc_pkg::msc_tx_s TX0 = '0;

  msc_stats DUT (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus), .rd_data(rd_data), .rx_ev(rx_ev),
    .tx_ev(tx_ev), .ser_clk(ser_clk), .ser_sync(ser_sync), .ser_rxd(ser_rxd), .rx_gate(rx_gate),
    .long_frame_en(long_frame_en), .full_duplex(full_duplex), .speed_100(speed_100),
    .pause_quantum(pause_quantum));
  msc_phy_model PHY (.en(phy_en), .st(phy_st), .ser_clk(ser_clk), .ser_sync(ser_sync), .ser_rxd(ser_rxd));

  // Clock generation and hang guard
  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bus cycles: one strobe cycle, read data taken in the following cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk) bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge sys_clk) bus <= '0;
    #1 d = rd_data;
  endtask
  task automatic ev(input msc_pkg::msc_rx_s r, input msc_pkg::msc_tx_s t);
    @(posedge sys_clk) begin
      rx_ev <= r;
      tx_ev <= t;
    end
    @(posedge sys_clk) begin
      rx_ev <= '0;
      tx_ev <= '0;
    end
  endtask

  function automatic msc_pkg::msc_rx_s mr(logic c, logic d, logic s, logic p, logic [13:0] n);
    return '{done: 1'b1, crc_bad: c, dribble: d, sym_err: s, pause: p, len: n};
  endfunction
  function automatic msc_pkg::msc_tx_s mt(logic [6:0] f, logic [4:0] n);
    return '{done: 1'b1, underrun: f[6], abandoned: f[5], late: f[4], deferred: f[3],
             crs_err: f[2], sqe_miss: f[1], pause: f[0], coll: n};
  endfunction
  task automatic add(logic g, logic [1:0] c, msc_pkg::msc_rx_s r, msc_pkg::msc_tx_s t, logic [17:0] m);
    rows.push_back('{g, c, r, t, m});
  endtask

  initial begin
    bus = '0;
    rx_ev = '0;
    tx_ev = '0;
    rst_b = 1'b0;
    phy_en = 1'b0;
    phy_st = 5'h16;
    cyc = 0;
    // Rows: gate, {full duplex, long frames}, event, counters expected to step
    add(1, 2'h0, mr(0, 0, 0, 0, 14'h0064), TX0, 18'h00010);
    add(1, 2'h0, mr(0, 0, 0, 1, 14'h0040), TX0, 18'h00011);
    add(1, 2'h0, mr(1, 0, 0, 0, 14'h05EE), TX0, 18'h00020);
    add(1, 2'h0, mr(1, 1, 0, 0, 14'h0040), TX0, 18'h00040);
    add(1, 2'h0, mr(0, 0, 0, 0, 14'h05EF), TX0, 18'h02000);
    add(1, 2'h1, mr(0, 0, 0, 0, 14'h05EF), TX0, 18'h00010);
    add(1, 2'h0, mr(0, 0, 0, 0, 14'h07D0), TX0, 18'h02000);
    add(1, 2'h1, mr(0, 0, 0, 0, 14'h07D0), TX0, 18'h00010);
    add(1, 2'h1, mr(1, 0, 0, 0, 14'h07D1), TX0, 18'h04000);
    add(1, 2'h0, mr(0, 0, 0, 0, 14'h003F), TX0, 18'h08000);
    add(1, 2'h0, mr(0, 0, 1, 0, 14'h0064), TX0, 18'h01000);
    add(0, 2'h0, mr(0, 0, 0, 0, 14'h0064), TX0, 18'h00000);
    add(1, 2'h0, RX0, mt(7'h00, 5'h00), 18'h00002);
    add(1, 2'h0, RX0, mt(7'h00, 5'h01), 18'h00006);
    add(1, 2'h0, RX0, mt(7'h00, 5'h03), 18'h0000A);
    add(1, 2'h0, RX0, mt(7'h08, 5'h00), 18'h00082);
    add(1, 2'h0, RX0, mt(7'h10, 5'h01), 18'h00106);
    add(1, 2'h0, RX0, mt(7'h20, 5'h10), 18'h00200);
    add(1, 2'h0, RX0, mt(7'h49, 5'h01), 18'h00400);
    add(1, 2'h0, RX0, mt(7'h04, 5'h00), 18'h00802);
    add(1, 2'h2, RX0, mt(7'h04, 5'h00), 18'h00002);
    add(1, 2'h0, RX0, mt(7'h02, 5'h00), 18'h10002);
    add(1, 2'h0, RX0, mt(7'h01, 5'h00), 18'h20002);
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    // Reset values
    chk({16'h0, pause_quantum}, 32'h0000FFFF);
    rd(msc_pkg::OFF_PQUANT, v);
    chk(v, 32'h0000FFFF);
    rd(msc_pkg::OFF_SER_STAT, v);
    chk(v, 32'h0);
    $display("test reset done");
    // Table of events, then every counter is read back and cleared
    foreach (rows[k]) begin
      wr(msc_pkg::OFF_NET_CTRL, {29'h0, rows[k].gate, 2'h0});
      wr(msc_pkg::OFF_NET_CFG, {23'h0, rows[k].cfg[0], 6'h0, rows[k].cfg[1], 1'b0});
      ev(rows[k].rx, rows[k].tx);
      for (int i = 0; i < msc_pkg::NCNT; i++) begin
        rd(msc_pkg::CNT_OFF[i], v);
        chk(v, {31'h0, rows[k].m[i]});
      end
      $display("test row %0d done", k);
    end
    // Saturation at all ones, then clear on read
    repeat (257) ev(mr(1, 0, 0, 0, 14'h0064), TX0);
    rd(msc_pkg::CNT_OFF[msc_pkg::C_FCS], v);
    chk(v, 32'h000000FF);
    rd(msc_pkg::CNT_OFF[msc_pkg::C_FCS], v);
    chk(v, 32'h0);
    $display("test saturate done");
    // A transmit event in the cycle of a clearing read is kept
    @(posedge sys_clk) begin
      bus <= '{wr: 1'b0, rd: 1'b1, addr: msc_pkg::CNT_OFF[msc_pkg::C_TXGOOD], wdata: 32'h0};
      tx_ev <= mt(7'h00, 5'h00);
    end
    @(posedge sys_clk) begin
      bus <= '0;
      tx_ev <= '0;
    end
    #1 chk(rd_data, 32'h0);
    rd(msc_pkg::CNT_OFF[msc_pkg::C_TXGOOD], v);
    chk(v, 32'h1);
    $display("test read with event done");
    // Writes to a counter, upper bits and an unmapped address
    ev(mr(1, 0, 0, 0, 14'h0064), TX0);
    wr(msc_pkg::CNT_OFF[msc_pkg::C_FCS], 32'hFFFFFFFF);
    rd(msc_pkg::CNT_OFF[msc_pkg::C_FCS], v);
    chk(v, 32'h00000001);
    rd(8'h10, v);
    chk(v, 32'h0);
    wr(msc_pkg::OFF_PQUANT, 32'hABCD1234);
    wr(msc_pkg::OFF_NET_CFG, 32'h00000103);
    rd(msc_pkg::OFF_PQUANT, v);
    chk(v, 32'h00001234);
    chk({28'h0, rx_gate, long_frame_en, full_duplex, speed_100}, 32'h0000000F);
    chk({16'h0, pause_quantum}, 32'h00001234);
    $display("test registers done");
    // Reset in mid-run clears counters and restores register defaults
    ev(mr(1, 0, 0, 0, 14'h0064), TX0);
    @(posedge sys_clk) rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    chk({16'h0, pause_quantum}, 32'h0000FFFF);
    chk({28'h0, rx_gate, long_frame_en, full_duplex, speed_100}, 32'h0);
    rd(msc_pkg::CNT_OFF[msc_pkg::C_FCS], v);
    chk(v, 32'h0);
    $display("test mid-run reset done");
    // Status recovered from the serial stream
    phy_en = 1'b1;
    repeat (300) @(posedge sys_clk);
    phy_en = 1'b0;
    repeat (100) @(posedge sys_clk);
    rd(msc_pkg::OFF_SER_STAT, v);
    chk(v, 32'h00160000);
    $display("test serial status done");
    report_and_stop();
  end
endmodule
